// *** bmf_pkg.sv ***
// Shared constants, types and helpers for the bus-matching FIFO port control
package bmf_pkg;

   // ==========================================================
   // Widths and sizes
   localparam int DATA_W = 72;
   localparam int OFS_W = 16;
   localparam int DEPTH_DEF = 512;
   localparam int PAR_BIT = 8;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {BMF_W72, BMF_W36, BMF_W18} bmf_width_t;

   typedef struct packed {
      logic big_endian;
      logic zero_lat_rt;
      logic sync_flags;
      logic interspersed;
      logic serial_prog;
      logic fall_through;
      logic [2:0] dflt_sel;
      bmf_width_t wr_w;
      bmf_width_t rd_w;
   } bmf_cfg_t;

   typedef struct packed {
      logic [OFS_W-1:0] full_ofs;
      logic [OFS_W-1:0] empty_ofs;
   } bmf_ofs_t;

   // ==========================================================
   // Reset values
   localparam bmf_cfg_t CFG_RST = '0;
   localparam bmf_ofs_t OFS_RST = '0;
   localparam logic [OFS_W-1:0] DFLT_OFS [8] = '{
      16'h0007, 16'h000f, 16'h001f, 16'h003f,
      16'h007f, 16'h00ff, 16'h01ff, 16'h03ff
   };

   // ==========================================================
   // Helpers
   function automatic logic [3:0] width_pair(input logic match, input logic wr_sel,
                                             input logic rd_sel);
      logic [3:0] r;
      r = {BMF_W72, BMF_W72};
      if (match)
      begin
         case ({wr_sel, rd_sel})
            2'b10: r = {BMF_W36, BMF_W72};
            2'b11: r = {BMF_W18, BMF_W72};
            2'b00: r = {BMF_W72, BMF_W36};
            default: r = {BMF_W72, BMF_W18};
         endcase
      end
      return r;
   endfunction

   function automatic logic [1:0] last_piece(input bmf_width_t w);
      logic [1:0] r;
      case (w)
         BMF_W36: r = 2'h1;
         BMF_W18: r = 2'h3;
         default: r = 2'h0;
      endcase
      return r;
   endfunction

   // Big-endian walks from the most significant piece down
   function automatic logic [1:0] piece_pos(input logic [1:0] cnt, input bmf_width_t w,
                                            input logic big);
      return big ? 2'(last_piece(w) - cnt) : cnt;
   endfunction

   function automatic logic [DATA_W-1:0] get_piece(input logic [DATA_W-1:0] word,
                                                   input bmf_width_t w, input logic [1:0] pos);
      logic [DATA_W-1:0] r;
      case (w)
         BMF_W36: r = pos[0] ? {36'h0, word[71:36]} : {36'h0, word[35:0]};
         BMF_W18: r = {54'h0, word[18*pos +: 18]};
         default: r = word;
      endcase
      return r;
   endfunction

   function automatic logic [DATA_W-1:0] put_piece(input logic [DATA_W-1:0] word,
                                                   input logic [DATA_W-1:0] din,
                                                   input bmf_width_t w, input logic [1:0] pos);
      logic [DATA_W-1:0] r;
      r = word;
      case (w)
         BMF_W36: if (pos[0]) r[71:36] = din[35:0]; else r[35:0] = din[35:0];
         BMF_W18: r[18*pos +: 18] = din[17:0];
         default: r = din;
      endcase
      return r;
   endfunction

endpackage

// *** bmf_skid.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bmf_skid #(
   parameter int W = 72
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] ent0_r;
   logic [W-1:0] ent1_r;
   logic [1:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = ent0_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clock)
   begin
      if (!nrst || flush)
         cnt_r <= 2'h0;
      else
         cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
   end

   // Entry 0 is always the head; entry 1 only fills when 0 is busy
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         ent0_r <= '0;
         ent1_r <= '0;
      end
      else
      begin
         if (pop)
            ent0_r <= (cnt_r == 2'h2) ? ent1_r : in_data;
         else if (push && cnt_r == 2'h0)
            ent0_r <= in_data;
         if (push && (cnt_r == 2'h2 || (cnt_r == 2'h1 && !pop)))
            ent1_r <= in_data;
      end
   end
endmodule
`default_nettype wire

// *** bmf_top.sv ***
// Bus-matching FIFO with reset-latched configuration and offset programming
`timescale 1ns/1ps
`default_nettype none
module bmf_top
#(
   parameter int DEPTH = bmf_pkg::DEPTH_DEF
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic master_reset_n,
   input wire logic partial_reset_n,
   input wire logic bus_match_sel,
   input wire logic write_width_sel,
   input wire logic read_width_sel,
   input wire logic word_order_sel,
   input wire logic retransmit_latency_sel,
   input wire logic flag_timing_sel,
   input wire logic parity_placement_sel,
   input wire logic flag_default_sel_lo,
   input wire logic flag_default_sel_hi,
   input wire logic fall_through_mode,
   input wire logic offset_load_n,
   input wire logic serial_enable_n,
   input wire logic write_en_n,
   input wire logic [bmf_pkg::DATA_W-1:0] data_in,
   input wire logic read_en_n,
   input wire logic read_chip_select_n,
   input wire logic output_enable_n,
   output logic [bmf_pkg::DATA_W-1:0] data_out,
   output logic data_out_oe,
   output logic full_ready_pin,
   output logic almost_empty_flag,
   output logic almost_full_flag,
   output bmf_pkg::bmf_cfg_t cfg_out,
   output bmf_pkg::bmf_ofs_t ofs_out
);
   import bmf_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // Configuration and offsets
   bmf_cfg_t cfg_r;
   bmf_ofs_t ofs_r;
   logic wofs_sel_r;
   logic rofs_sel_r;
   logic reset_active;
   logic wr;
   logic rd;
   logic [2:0] dsel;
   logic [OFS_W-1:0] par_ofs;
   logic [3:0] wpair;

   assign reset_active = !master_reset_n || !partial_reset_n;
   assign dsel = {offset_load_n, flag_default_sel_hi, flag_default_sel_lo};
   assign wpair = width_pair(bus_match_sel, write_width_sel, read_width_sel);
   assign wr = !write_en_n && !reset_active;
   // Chip select is taken at the edge itself, so a read needs both
   assign rd = !read_en_n && !read_chip_select_n && !reset_active;

   always_ff @(posedge clock)
   begin
      if (!nrst)
         cfg_r <= CFG_RST;
      else if (!master_reset_n)
      begin
         cfg_r.big_endian <= !word_order_sel;
         cfg_r.zero_lat_rt <= !retransmit_latency_sel;
         cfg_r.sync_flags <= flag_timing_sel;
         cfg_r.interspersed <= parity_placement_sel;
         cfg_r.dflt_sel <= dsel;
         cfg_r.serial_prog <= offset_load_n;
         cfg_r.fall_through <= fall_through_mode;
         cfg_r.wr_w <= bmf_width_t'(wpair[3:2]);
         cfg_r.rd_w <= bmf_width_t'(wpair[1:0]);
      end
   end

   // Interspersed parity skips bit 8; otherwise bits 16 and 17 are dropped
   assign par_ofs = cfg_r.interspersed ? {data_in[16:PAR_BIT+1], data_in[PAR_BIT-1:0]}
                                       : data_in[OFS_W-1:0];

   // Partial reset keeps the offsets and the programming method
   always_ff @(posedge clock)
   begin
      if (!nrst)
         ofs_r <= OFS_RST;
      else if (!master_reset_n)
      begin
         ofs_r.empty_ofs <= DFLT_OFS[dsel];
         ofs_r.full_ofs <= DFLT_OFS[dsel];
      end
      else if (!partial_reset_n)
         ofs_r <= ofs_r;
      else if (cfg_r.serial_prog && !serial_enable_n)
         ofs_r <= {ofs_r[2*OFS_W-2:0], fall_through_mode};
      else if (!cfg_r.serial_prog && wr && !offset_load_n)
      begin
         if (wofs_sel_r)
            ofs_r.full_ofs <= par_ofs;
         else
            ofs_r.empty_ofs <= par_ofs;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || reset_active)
         wofs_sel_r <= 1'b0;
      else if (!cfg_r.serial_prog && wr && !offset_load_n)
         wofs_sel_r <= !wofs_sel_r;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || reset_active)
         rofs_sel_r <= 1'b0;
      else if (rd && !offset_load_n)
         rofs_sel_r <= !rofs_sel_r;
   end

   // ==========================================================
   // Write side: piece assembly and memory
   logic [DATA_W-1:0] mem [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic [AW:0] count;
   logic full;
   logic empty;
   logic [1:0] wcnt_r;
   logic [DATA_W-1:0] asm_r;
   logic [DATA_W-1:0] asm_word;
   logic data_wr;
   logic wlast;

   assign count = wp_r - rp_r;
   assign full = (count == (AW+1)'(DEPTH));
   assign empty = (count == '0);
   assign data_wr = wr && offset_load_n && !full;
   assign wlast = (wcnt_r == last_piece(cfg_r.wr_w));
   assign asm_word = put_piece(asm_r, data_in, cfg_r.wr_w,
                               piece_pos(wcnt_r, cfg_r.wr_w, cfg_r.big_endian));

   always_ff @(posedge clock)
   begin
      if (!nrst || reset_active)
      begin
         wcnt_r <= 2'h0;
         asm_r <= '0;
      end
      else if (data_wr)
      begin
         asm_r <= asm_word;
         wcnt_r <= wlast ? 2'h0 : 2'(wcnt_r + 2'h1);
      end
   end

   always_ff @(posedge clock)
   begin
      if (data_wr && wlast)
         mem[wp_r[AW-1:0]] <= asm_word;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || reset_active)
         wp_r <= '0;
      else if (data_wr && wlast)
         wp_r <= wp_r + 1'b1;
   end

   // ==========================================================
   // Read side: prefetch buffer, piece split, output register
   logic sk_in_ready;
   logic sk_out_valid;
   logic sk_out_ready;
   logic [DATA_W-1:0] sk_out_data;
   logic pop;
   logic [1:0] rcnt_r;
   logic rlast;
   logic [DATA_W-1:0] data_out_r;
   logic cs_oe_r;

   // The buffer keeps a stalled consumer from losing a prefetched word
   assign pop = !empty && sk_in_ready && !reset_active;
   assign rlast = (rcnt_r == last_piece(cfg_r.rd_w));
   assign sk_out_ready = rd && offset_load_n && rlast;

   bmf_skid #(.W(DATA_W)) u_skid (
      .clock(clock),
      .nrst(nrst),
      .flush(reset_active),
      .in_valid(!empty && !reset_active),
      .in_ready(sk_in_ready),
      .in_data(mem[rp_r[AW-1:0]]),
      .out_valid(sk_out_valid),
      .out_ready(sk_out_ready),
      .out_data(sk_out_data)
   );

   always_ff @(posedge clock)
   begin
      if (!nrst || reset_active)
         rp_r <= '0;
      else if (pop)
         rp_r <= rp_r + 1'b1;
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || reset_active)
         rcnt_r <= 2'h0;
      else if (rd && offset_load_n && sk_out_valid)
         rcnt_r <= rlast ? 2'h0 : 2'(rcnt_r + 2'h1);
   end

   always_ff @(posedge clock)
   begin
      if (!nrst || reset_active)
         data_out_r <= '0;
      else if (rd && !offset_load_n)
         data_out_r <= {56'h0, rofs_sel_r ? ofs_r.full_ofs : ofs_r.empty_ofs};
      else if (rd && sk_out_valid)
         data_out_r <= get_piece(sk_out_data, cfg_r.rd_w,
                                 piece_pos(rcnt_r, cfg_r.rd_w, cfg_r.big_endian));
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
         cs_oe_r <= 1'b0;
      else
         cs_oe_r <= !read_chip_select_n;
   end

   assign data_out = data_out_r;
   // Output enable acts straight through, no clock in its path
   assign data_out_oe = !output_enable_n && (reset_active || cs_oe_r);

   // ==========================================================
   // Status flags
   logic ae_now;
   logic af_now;
   logic ae_r;
   logic af_r;
   logic [AW:0] free;

   // Same pin, both meanings reduce to space available
   assign full_ready_pin = cfg_r.fall_through ? !full : !full;
   assign free = (AW+1)'(DEPTH) - count;
   assign ae_now = ({{(OFS_W-AW-1){1'b0}}, count} < ofs_r.empty_ofs);
   assign af_now = ({{(OFS_W-AW-1){1'b0}}, free} <= ofs_r.full_ofs);

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         ae_r <= 1'b1;
         af_r <= 1'b0;
      end
      else
      begin
         ae_r <= ae_now;
         af_r <= af_now;
      end
   end

   assign almost_empty_flag = cfg_r.sync_flags ? ae_r : ae_now;
   assign almost_full_flag = cfg_r.sync_flags ? af_r : af_now;
   assign cfg_out = cfg_r;
   assign ofs_out = ofs_r;

   // ==========================================================
   // Checks
   cfg_latch_a: assert property (@(posedge clock) disable iff (!nrst)
      !master_reset_n |=> cfg_r.big_endian == !$past(word_order_sel)
         && cfg_r.zero_lat_rt == !$past(retransmit_latency_sel))
      else $error("mode latch wrong");
   flag_mode_a: assert property (@(posedge clock) disable iff (!nrst)
      !master_reset_n |=> cfg_r.sync_flags == $past(flag_timing_sel)
         && cfg_r.interspersed == $past(parity_placement_sel)
         && cfg_r.serial_prog == $past(offset_load_n))
      else $error("flag mode latch wrong");
   dflt_ofs_a: assert property (@(posedge clock) disable iff (!nrst)
      !master_reset_n |=> ofs_r.empty_ofs == DFLT_OFS[$past(dsel)])
      else $error("default offset wrong");
   width_sel_a: assert property (@(posedge clock) disable iff (!nrst)
      !master_reset_n && bus_match_sel && !write_width_sel && read_width_sel
         |=> cfg_r.wr_w == BMF_W72 && cfg_r.rd_w == BMF_W18)
      else $error("width table wrong");
   oe_async_a: assert property (@(posedge clock) disable iff (!nrst)
      output_enable_n |-> !data_out_oe)
      else $error("outputs driven while disabled");
   reset_oe_a: assert property (@(posedge clock) disable iff (!nrst)
      reset_active && !output_enable_n |-> data_out_oe)
      else $error("outputs floated during reset");
   rst_clear_a: assert property (@(posedge clock) disable iff (!nrst)
      !master_reset_n |=> wp_r == '0 && rp_r == '0 && data_out == '0)
      else $error("reset did not clear");
   serial_in_a: assert property (@(posedge clock) disable iff (!nrst)
      reset_active == 1'b0 && cfg_r.serial_prog && !serial_enable_n
         |=> ofs_r.empty_ofs[0] == $past(fall_through_mode))
      else $error("serial bit not shifted");
   full_drop_a: assert property (@(posedge clock) disable iff (!nrst)
      full && wr && offset_load_n && !rd |=> $stable(wp_r) && count <= $past(count))
      else $error("write taken while full");
   empty_read_a: assert property (@(posedge clock) disable iff (!nrst)
      rd && offset_load_n && !sk_out_valid |=> $stable(data_out))
      else $error("read taken while empty");
   status_pin_a: assert property (@(posedge clock) disable iff (!nrst)
      full_ready_pin == !full)
      else $error("status pin wrong");

   fill_full_c: cover property (@(posedge clock) disable iff (!nrst) full ##1 !full);
   narrow_rd_c: cover property (@(posedge clock) disable iff (!nrst)
      cfg_r.rd_w == BMF_W18 && rd && sk_out_valid && rlast);
   par_ofs_c: cover property (@(posedge clock) disable iff (!nrst)
      wr && !offset_load_n && wofs_sel_r);
endmodule
`default_nettype wire

// *** bmf_far_end.sv ***
// Producer and consumer model facing the FIFO write and read ports
`timescale 1ns/1ps
`default_nettype none
module bmf_far_end (
   input wire logic clock,
   output logic write_en_n,
   output logic [bmf_pkg::DATA_W-1:0] data_in,
   output logic read_en_n,
   output logic read_chip_select_n
);
   import bmf_pkg::*;

   initial
   begin
      write_en_n = 1'b1;
      data_in = '0;
      read_en_n = 1'b1;
      read_chip_select_n = 1'b1;
   end

   // ==========================================================
   // Producer
   task automatic put(input logic [DATA_W-1:0] w);
      @(negedge clock);
      write_en_n = 1'b0;
      data_in = w;
      @(posedge clock);
   endtask

   // Released bus shows the inverse, so stale data never looks valid
   task automatic put_end();
      @(negedge clock);
      write_en_n = 1'b1;
      data_in = ~data_in;
   endtask

   // ==========================================================
   // Consumer; chip select stays where it was last set
   task automatic get(input logic cs_n);
      @(negedge clock);
      read_en_n = 1'b0;
      read_chip_select_n = cs_n;
      @(posedge clock);
   endtask

   task automatic get_end();
      @(negedge clock);
      read_en_n = 1'b1;
   endtask

   task automatic sel(input logic cs_n);
      @(negedge clock);
      read_chip_select_n = cs_n;
   endtask
endmodule
`default_nettype wire

// *** bmf_top_tb_top.sv ***
// Self-checking bench for the bus-matching FIFO port control
`timescale 1ns/1ps
`default_nettype none
module bmf_top_tb_top;
   import bmf_pkg::*;
   localparam int DEPTH = 4;
   logic clock = 1'b0;
   logic nrst, master_reset_n, partial_reset_n;
   logic bus_match_sel, write_width_sel, read_width_sel, word_order_sel;
   logic retransmit_latency_sel, flag_timing_sel, parity_placement_sel;
   logic flag_default_sel_hi, flag_default_sel_lo;
   logic ft_si, load_n, serial_enable_n, oe_n;
   logic write_en_n, read_en_n, read_chip_select_n, data_out_oe, full_ready_pin;
   logic almost_empty_flag, almost_full_flag;
   logic [DATA_W-1:0] data_in, data_out;
   bmf_cfg_t cfg_out;
   bmf_ofs_t ofs_out;
   int errors = 0;
   int total_checks = 0;

   always #5 clock = ~clock;

   bmf_far_end u_bmf_far_end (
      .clock(clock),
      .write_en_n(write_en_n),
      .data_in(data_in),
      .read_en_n(read_en_n),
      .read_chip_select_n(read_chip_select_n)
   );

   bmf_top #(.DEPTH(DEPTH)) u_bmf_top (
      .clock(clock),
      .nrst(nrst),
      .master_reset_n(master_reset_n),
      .partial_reset_n(partial_reset_n),
      .bus_match_sel(bus_match_sel),
      .write_width_sel(write_width_sel),
      .read_width_sel(read_width_sel),
      .word_order_sel(word_order_sel),
      .retransmit_latency_sel(retransmit_latency_sel),
      .flag_timing_sel(flag_timing_sel),
      .parity_placement_sel(parity_placement_sel),
      .flag_default_sel_hi(flag_default_sel_hi),
      .flag_default_sel_lo(flag_default_sel_lo),
      .fall_through_mode(ft_si),
      .offset_load_n(load_n),
      .serial_enable_n(serial_enable_n),
      .write_en_n(write_en_n),
      .data_in(data_in),
      .read_en_n(read_en_n),
      .read_chip_select_n(read_chip_select_n),
      .output_enable_n(oe_n),
      .data_out(data_out),
      .data_out_oe(data_out_oe),
      .full_ready_pin(full_ready_pin),
      .almost_empty_flag(almost_empty_flag),
      .almost_full_flag(almost_full_flag),
      .cfg_out(cfg_out),
      .ofs_out(ofs_out)
   );

   // ==========================================================
   // Checking and closing
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: flag %b want %b", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // Helpers
   // Straps flip after release so a live read of them would show
   task automatic set_straps(input logic [8:0] s);
      {bus_match_sel, write_width_sel, read_width_sel, word_order_sel, retransmit_latency_sel,
       flag_timing_sel, parity_placement_sel, flag_default_sel_hi, flag_default_sel_lo} = s;
   endtask

   task automatic mres(input logic [8:0] s, input logic load, input logic ft);
      @(negedge clock);
      set_straps(s);
      load_n = load;
      ft_si = ft;
      master_reset_n = 1'b0;
      repeat (2) @(negedge clock);
      master_reset_n = 1'b1;
      load_n = 1'b1;
      ft_si = 1'b0;
      set_straps(~s);
   endtask

   function automatic logic [71:0] piece(input logic [71:0] w, input int n, input int j,
                                         input logic big);
      int p;
      p = big ? n - 1 - j : j;
      return (w >> (p * (72 / n))) & ((72'h1 << (72 / n)) - 72'h1);
   endfunction

   // ==========================================================
   // Scenarios
   task automatic t_width(input logic [8:0] s, input int nw, input int nr);
      logic [71:0] w = 72'h123456789abcdef0f1;
      mres(s, 1'b1, 1'b0);
      for (int j = 0; j < nw; j++)
         u_bmf_far_end.put(piece(w, nw, j, ~s[5]));
      u_bmf_far_end.put_end();
      repeat (2) @(negedge clock);
      for (int j = 0; j < nr; j++)
      begin
         u_bmf_far_end.get(1'b0);
         #1;
         chk(data_out, piece(w, nr, j, ~s[5]));
      end
      u_bmf_far_end.get_end();
   endtask

   task automatic t_full(input logic ft);
      int n = 0;
      mres(9'h0, 1'b1, ft);
      #1;
      while (full_ready_pin === 1'b1 && n < 16)
      begin
         u_bmf_far_end.put(72'(n) + 72'h700);
         n++;
         #1;
      end
      chk_bit(n < 16 && n >= DEPTH, 1'b1);
      u_bmf_far_end.put(72'hbad);
      u_bmf_far_end.put_end();
      chk_bit(full_ready_pin, 1'b0);
      repeat (2) @(negedge clock);
      for (int j = 0; j <= n; j++)
      begin
         u_bmf_far_end.get(1'b0);
         u_bmf_far_end.get_end();
         @(negedge clock);
         chk(data_out, 72'(j < n ? j : n - 1) + 72'h700);
      end
      chk_bit(full_ready_pin, 1'b1);
   endtask

   task automatic t_oe();
      logic [71:0] c;
      u_bmf_far_end.sel(1'b1);
      set_straps(9'h0);
      master_reset_n = 1'b0;
      @(posedge clock);
      #1;
      chk_bit(data_out_oe, 1'b1);
      chk(data_out, '0);
      @(negedge clock);
      oe_n = 1'b1;
      #1;
      chk_bit(data_out_oe, 1'b0);
      @(negedge clock);
      master_reset_n = 1'b1;
      oe_n = 1'b0;
      @(posedge clock);
      #1;
      chk_bit(data_out_oe, 1'b0);
      u_bmf_far_end.put(72'h5a5);
      u_bmf_far_end.put_end();
      repeat (2) @(negedge clock);
      u_bmf_far_end.get(1'b1);
      u_bmf_far_end.get_end();
      chk(data_out, '0);
      u_bmf_far_end.sel(1'b0);
      #1;
      chk_bit(data_out_oe, 1'b0);
      @(posedge clock);
      #1;
      chk_bit(data_out_oe, 1'b1);
      @(negedge clock);
      oe_n = 1'b1;
      #1;
      chk_bit(data_out_oe, 1'b0);
      @(negedge clock);
      oe_n = 1'b0;
      u_bmf_far_end.get(1'b0);
      u_bmf_far_end.get_end();
      chk(data_out, 72'h5a5);
      c = 72'(cfg_out);
      partial_reset_n = 1'b0;
      u_bmf_far_end.sel(1'b1);
      @(posedge clock);
      #1;
      chk_bit(data_out_oe, 1'b1);
      chk(data_out, '0);
      chk(72'(cfg_out), c);
      @(negedge clock);
      partial_reset_n = 1'b1;
   endtask

   task automatic t_ser();
      logic [31:0] p = 32'h0003_0002;
      mres(9'h0, 1'b1, 1'b0);
      for (int k = 31; k >= 0; k--)
      begin
         if (k == 15)
         begin
            @(negedge clock);
            serial_enable_n = 1'b1;
            ft_si = ~ft_si;
         end
         @(negedge clock);
         serial_enable_n = 1'b0;
         ft_si = p[k];
      end
      @(negedge clock);
      serial_enable_n = 1'b1;
      ft_si = ~ft_si;
      chk(72'(ofs_out), 72'(p));
      chk_bit(almost_empty_flag, 1'b1);
      chk_bit(almost_full_flag, 1'b0);
      for (int j = 0; j < 4; j++)
         u_bmf_far_end.put(72'(j));
      u_bmf_far_end.put_end();
      repeat (2) @(negedge clock);
      chk_bit(almost_empty_flag, 1'b0);
      chk_bit(almost_full_flag, 1'b1);
   endtask

   task automatic t_par(input logic par_mode);
      logic [71:0] a = 72'h3_a5c3;
      logic [71:0] b = 72'h1_5e7f;
      logic [15:0] fa, fb;
      fa = par_mode ? {a[16:9], a[7:0]} : a[15:0];
      fb = par_mode ? {b[16:9], b[7:0]} : b[15:0];
      mres({6'h0, par_mode, 2'b00}, 1'b0, 1'b0);
      @(negedge clock);
      load_n = 1'b0;
      u_bmf_far_end.put(a);
      u_bmf_far_end.put(b);
      u_bmf_far_end.put_end();
      load_n = 1'b1;
      serial_enable_n = 1'b0;
      ft_si = 1'b1;
      @(negedge clock);
      serial_enable_n = 1'b1;
      chk(72'(ofs_out), 72'({fb, fa}));
      u_bmf_far_end.get(1'b0);
      u_bmf_far_end.get_end();
      chk(data_out, '0);
      load_n = 1'b0;
      u_bmf_far_end.get(1'b0);
      #1;
      chk(data_out, 72'(fa));
      u_bmf_far_end.get(1'b0);
      #1;
      chk(data_out, 72'(fb));
      u_bmf_far_end.get_end();
      load_n = 1'b1;
   endtask

   task automatic t_cfg();
      logic [2:0] wt [5] = '{3'b000, 3'b110, 3'b111, 3'b100, 3'b101};
      bmf_width_t ww [5] = '{BMF_W72, BMF_W36, BMF_W18, BMF_W72, BMF_W72};
      bmf_width_t rw [5] = '{BMF_W72, BMF_W72, BMF_W72, BMF_W36, BMF_W18};
      bmf_cfg_t e;
      logic [2:0] i;
      for (int k = 0; k < 8; k++)
      begin
         i = 3'(k);
         mres({wt[k % 5], i[0], i[1], i[2], ~i[0], i[1], i[0]}, i[2], i[1] ^ i[0]);
         e.big_endian = ~i[0];
         e.zero_lat_rt = ~i[1];
         e.sync_flags = i[2];
         e.interspersed = ~i[0];
         e.serial_prog = i[2];
         e.fall_through = i[1] ^ i[0];
         e.dflt_sel = i;
         e.wr_w = ww[k % 5];
         e.rd_w = rw[k % 5];
         @(negedge clock);
         chk(72'(cfg_out), 72'(e));
         chk(72'(ofs_out), 72'({DFLT_OFS[k], DFLT_OFS[k]}));
         chk(data_out, '0);
         chk_bit(full_ready_pin, 1'b1);
      end
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      nrst = 1'b0;
      master_reset_n = 1'b1;
      partial_reset_n = 1'b1;
      set_straps(9'h0);
      ft_si = 1'b0;
      load_n = 1'b1;
      serial_enable_n = 1'b1;
      oe_n = 1'b0;
      repeat (5) @(negedge clock);
      nrst = 1'b1;
      t_width(9'b101_000000, 1, 4);
      t_width(9'b100_100000, 1, 2);
      t_width(9'b111_000000, 4, 1);
      t_width(9'b110_100000, 2, 1);
      t_width(9'b000_000000, 1, 1);
      t_full(1'b0);
      t_full(1'b1);
      t_oe();
      t_ser();
      t_par(1'b0);
      t_par(1'b1);
      t_cfg();
      final_report();
   end

   // Cuts a hang short
   initial
   begin
      #200000;
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
   end
endmodule
`default_nettype wire
